//--- hdl/cgw_pkg.sv
// Purpose: shared constants for the cpu clock generator and osc watchdog
// Assumes: a 125 MHz system clock, 8 ns per cycle
// Notes:   mode codes come from the three clock mode pins
package cgw_pkg;
	// system clock period in picoseconds (8 ns)
	localparam int unsigned SYS_PERIOD_PS = 8000;
	// free-running pll period in nanoseconds, a plain model value
	localparam int unsigned FREE_PERIOD_NS = 64;
	// half period of the free-running clock in system cycles, rounded down
	localparam int unsigned FREE_HALF_CYC =
		(FREE_PERIOD_NS * 1000 / 2) / SYS_PERIOD_PS;
	// watchdog overflow after this many free-running cycles
	localparam int unsigned OWD_LIMIT = 16;
	// free-running cycles without reference edge that count as unlock
	localparam int unsigned LOCK_LIMIT = 32;
	// system cycles after reset release before the mode pins are taken
	localparam logic [1:0] MODE_TAKE_CNT = 2'h2;
	// position of the oscillator watchdog disable bit in system config
	localparam int unsigned OWD_DIS_BIT = 4;
	// width of the system config word
	localparam int unsigned SYSCFG_W = 16;
	// clock mode codes on the mode pins
	localparam logic [2:0] MODE_X4 = 3'h7;
	localparam logic [2:0] MODE_X3 = 3'h6;
	localparam logic [2:0] MODE_X8 = 3'h5;
	localparam logic [2:0] MODE_X5 = 3'h4;
	localparam logic [2:0] MODE_DIRECT = 3'h3;
	localparam logic [2:0] MODE_X10 = 3'h2;
	localparam logic [2:0] MODE_PRESC = 3'h1;
	localparam logic [2:0] MODE_X16 = 3'h0;
	// mode held until the pins are taken: the default x4
	localparam logic [2:0] MODE_RST = MODE_X4;
	// width of the period measurement
	localparam int unsigned PER_W = 16;

	// multiplication factor of a mode, zero for the prescaler mode and one for direct drive
	function automatic logic [4:0] cgw_factor(input logic [2:0] code);
		unique case (code)
			MODE_X4: cgw_factor = 5'h04;
			MODE_X3: cgw_factor = 5'h03;
			MODE_X8: cgw_factor = 5'h08;
			MODE_X5: cgw_factor = 5'h05;
			MODE_X10: cgw_factor = 5'h0A;
			MODE_X16: cgw_factor = 5'h10;
			MODE_DIRECT: cgw_factor = 5'h01;
			MODE_PRESC: cgw_factor = 5'h00;
		endcase
	endfunction : cgw_factor

	// true where the pll multiplies the input clock
	function automatic logic cgw_is_mult(input logic [2:0] code);
		cgw_is_mult = (code != MODE_DIRECT) && (code != MODE_PRESC);
	endfunction : cgw_is_mult
endpackage : cgw_pkg

//--- hdl/cgw_free_osc.sv
// Purpose: model of the pll free-running oscillator
// Assumes: derived from the system clock by a fixed divider
// Notes:   stops and holds low while disabled
`timescale 1ns/1ps
module cgw_free_osc import cgw_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic en_i,
	// free-running clock level and its rising-edge pulse
	output logic lvl_o,
	output logic tick_o
);
	logic [7:0] cnt_r; // half-period counter
	logic [7:0] cnt_nxt;
	logic lvl_nxt;
	logic tick_nxt;

	// divide the system clock, restart cleanly when enabled again
	always_comb begin
		cnt_nxt = cnt_r + 8'h01;
		lvl_nxt = lvl_o;
		tick_nxt = 1'b0;
		if (!en_i) begin
			cnt_nxt = 8'h00;
			lvl_nxt = 1'b0;
		end else if (cnt_r == 8'(FREE_HALF_CYC - 1)) begin
			cnt_nxt = 8'h00;
			lvl_nxt = !lvl_o;
			tick_nxt = !lvl_o; // pulse on the rising half only
		end
	end

	// register the divider
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= 8'h00;
			lvl_o <= 1'b0;
			tick_o <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			lvl_o <= lvl_nxt;
			tick_o <= tick_nxt;
		end
	end
endmodule : cgw_free_osc

//--- hdl/cgw_tick_wdog.sv
// Purpose: counts free-running ticks, cleared by reference transitions
// Assumes: tick and clear are one-cycle pulses on the system clock
// Notes:   overflow is a single pulse; clear wins over a tick
`timescale 1ns/1ps
module cgw_tick_wdog import cgw_pkg::*; #(
	parameter int unsigned LIMIT = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// count control
	input wire logic en_i,
	input wire logic tick_i,
	input wire logic clr_i,
	// overflow pulse
	output logic ovf_o
);
	logic [6:0] cnt_r; // ticks since the last transition
	logic [6:0] cnt_nxt;
	logic ovf_nxt;

	// count ticks; a transition restarts the count
	always_comb begin
		cnt_nxt = cnt_r;
		ovf_nxt = 1'b0;
		if (!en_i || clr_i) begin
			cnt_nxt = 7'h00;
		end else if (tick_i) begin
			if (cnt_r == 7'(LIMIT - 1)) begin
				cnt_nxt = 7'h00;
				ovf_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 7'h01;
			end
		end
	end

	// register the counter
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= 7'h00;
			ovf_o <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			ovf_o <= ovf_nxt;
		end
	end
endmodule : cgw_tick_wdog

//--- hdl/cgw_clock_gen.sv
// Purpose: cpu clock generation with oscillator watchdog and pll backup
// Assumes: osc input and mode pins are asynchronous to clk_i
// Notes:   the cpu clock is a sampled model, edges fall on clk_i edges
// Function
// - both cpu clock edges usable; edge pulse given
// - clock method chosen from mode pins at reset
// - mode code sets the cpu clock factor
// - code 001 divides oscillator by two
// - prescaler phases each last one input period
// - code 011 bypasses pll and amplifier, direct drive
// - direct drive halves follow input duty cycle
// - non-pll modes: pll free-runs unless watchdog disabled
// - watchdog on after reset, config bit 4 disables
// - watchdog only in direct and prescaler modes
// - pll ticks count up, input transitions clear
// - overflow after 16 ticks without a transition
// - overflow switches to pll clock, raises irq
// - backup clock held until the next reset
// - watchdog off in non-pll modes: oscillator path only, pll off
// - codes other than 011 and 001 enable the multiplying pll
// - pll resyncs every F transitions, smoothly; odd F waits for the next rise, so every F+1
// - unlock raises irq, disconnects reference, free-runs
`timescale 1ns/1ps
module cgw_clock_gen import cgw_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pins from the clock source and the mode straps
	input wire logic osc_input_pin_i,
	input wire logic [2:0] clock_mode_pins_i,
	// system configuration word and flag clears
	input wire logic [SYSCFG_W-1:0] system_config_register_i,
	input wire logic owd_irq_clr_i,
	input wire logic unlock_irq_clr_i,
	// generated cpu clock and its edge pulse
	output logic cpu_clk_o,
	output logic cpu_clk_edge_o,
	// status of the generator
	output logic [2:0] clock_mode_o,
	output logic [4:0] clk_factor_o,
	output logic pll_on_o,
	output logic osc_amp_bypass_o,
	output logic backup_active_o,
	// interrupt requests
	output logic owd_irq_o,
	output logic unlock_irq_o
);
	// pin synchronisers; only the second stage onward is read by logic
	logic xs1_r, xs2_r, xs3_r;
	logic [2:0] mp1_r, mp2_r;
	logic x_rise, x_tran; // input rising edge and any transition

	// mode latch
	logic [1:0] take_cnt_r, take_cnt_nxt;
	logic [2:0] mode_r, mode_nxt;
	logic taken_r, taken_nxt;

	// pll model
	logic [PER_W-1:0] per_cnt_r, per_cnt_nxt; // cycles since last rise
	logic [PER_W-1:0] per_r, per_nxt; // period applied to the pll
	logic [PER_W:0] acc_r, acc_nxt; // phase accumulator
	logic [4:0] tcnt_r, tcnt_nxt; // transitions since last resync
	logic pll_lvl_r, pll_lvl_nxt;

	// supervision
	logic fail_r, fail_nxt; // oscillator watchdog fired
	logic ref_conn_r, ref_conn_nxt; // reference reaches the pll
	logic owd_irq_nxt, unlock_irq_nxt;

	// cpu clock and status outputs
	logic cpu_clk_nxt, edge_nxt, pll_on_nxt, bypass_nxt;

	// helpers
	logic owd_dis; // watchdog disable bit
	logic is_mult; // pll multiplies in this mode
	logic wd_en, lk_en, wd_ovf, lk_ovf;
	logic free_lvl, free_tick;
	logic [4:0] fac;
	logic [PER_W:0] step;

	assign owd_dis = system_config_register_i[OWD_DIS_BIT];
	assign is_mult = cgw_is_mult(mode_r);
	assign fac = cgw_factor(mode_r);
	assign x_rise = xs2_r && !xs3_r;
	assign x_tran = xs2_r ^ xs3_r;
	// two cpu half-periods per output cycle, so the phase step is 2F
	assign step = {{(PER_W-5){1'b0}}, fac, 1'b0};

	// watchdog runs only in non-multiplying modes, enabled by default
	assign wd_en = taken_r && !is_mult && !owd_dis && !fail_r;
	// lock supervision runs while the reference still feeds the pll
	assign lk_en = taken_r && is_mult && ref_conn_r;

	// free-running pll oscillator, powered as pll_on says
	cgw_free_osc u_free (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(pll_on_o),
		.lvl_o(free_lvl),
		.tick_o(free_tick)
	);

	// oscillator watchdog: ticks count up, transitions clear
	cgw_tick_wdog #(.LIMIT(OWD_LIMIT)) u_owd (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(wd_en),
		.tick_i(free_tick),
		.clr_i(x_tran),
		.ovf_o(wd_ovf)
	);

	// lock monitor: a long absence of reference edges means unlock
	cgw_tick_wdog #(.LIMIT(LOCK_LIMIT)) u_lock (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(lk_en),
		.tick_i(free_tick),
		.clr_i(x_tran),
		.ovf_o(lk_ovf)
	);

	// synchronisers for the asynchronous pins
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			xs1_r <= 1'b0;
			xs2_r <= 1'b0;
			xs3_r <= 1'b0;
			mp1_r <= MODE_RST;
			mp2_r <= MODE_RST;
		end else begin
			xs1_r <= osc_input_pin_i;
			xs2_r <= xs1_r;
			xs3_r <= xs2_r;
			mp1_r <= clock_mode_pins_i;
			mp2_r <= mp1_r;
		end
	end

	// mode latch: waits for the sync chain to fill, then takes once
	always_comb begin
		take_cnt_nxt = take_cnt_r;
		mode_nxt = mode_r;
		taken_nxt = taken_r;
		if (!taken_r) begin
			if (take_cnt_r == MODE_TAKE_CNT) begin
				mode_nxt = mp2_r;
				taken_nxt = 1'b1;
			end else begin
				take_cnt_nxt = take_cnt_r + 2'h1;
			end
		end
		// once taken the code stays until the next reset
	end

	// register the mode latch
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			take_cnt_r <= 2'h0;
			mode_r <= MODE_RST;
			taken_r <= 1'b0;
		end else begin
			take_cnt_r <= take_cnt_nxt;
			mode_r <= mode_nxt;
			taken_r <= taken_nxt;
		end
	end

	// pll model: measure the input period, generate F cycles per period
	always_comb begin
		per_cnt_nxt = per_cnt_r;
		per_nxt = per_r;
		tcnt_nxt = tcnt_r;
		acc_nxt = acc_r;
		pll_lvl_nxt = pll_lvl_r;
		if (is_mult && ref_conn_r) begin
			if (per_cnt_r != {PER_W{1'b1}}) begin
				per_cnt_nxt = per_cnt_r + 1'b1;
			end
			if (x_rise) begin
				per_cnt_nxt = '0;
			end
			if (x_tran) begin
				if (tcnt_r + 5'h01 >= fac && x_rise) begin
					// every F'th transition, taken at a rise so that a
					// whole period is measured, updates the period only;
					// the phase is kept, so the clock never jumps
					tcnt_nxt = 5'h00;
					if (per_cnt_r != '0) begin
						per_nxt = per_cnt_r + 1'b1;
					end
				end else if (tcnt_r + 5'h01 < fac) begin
					tcnt_nxt = tcnt_r + 5'h01;
				end
				// an odd factor lands the due count on a fall: it
				// waits there for the next rise instead of being lost
			end
			if (per_r != '0) begin
				// toggle when the phase passes one input period
				acc_nxt = acc_r + step;
				if (acc_nxt >= {1'b0, per_r}) begin
					acc_nxt = acc_nxt - {1'b0, per_r};
					pll_lvl_nxt = !pll_lvl_r;
				end
			end
		end
	end

	// register the pll model
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			per_cnt_r <= '0;
			per_r <= '0;
			tcnt_r <= 5'h00;
			acc_r <= '0;
			pll_lvl_r <= 1'b0;
		end else begin
			per_cnt_r <= per_cnt_nxt;
			per_r <= per_nxt;
			tcnt_r <= tcnt_nxt;
			acc_r <= acc_nxt;
			pll_lvl_r <= pll_lvl_nxt;
		end
	end

	// supervision: sticky failure, reference disconnect, irq flags
	always_comb begin
		fail_nxt = fail_r;
		ref_conn_nxt = ref_conn_r;
		owd_irq_nxt = owd_irq_o;
		unlock_irq_nxt = unlock_irq_o;
		// software clears first so that a same-cycle event wins
		if (owd_irq_clr_i) begin
			owd_irq_nxt = 1'b0;
		end
		if (unlock_irq_clr_i) begin
			unlock_irq_nxt = 1'b0;
		end
		if (wd_ovf) begin
			fail_nxt = 1'b1; // held until reset
			owd_irq_nxt = 1'b1;
		end
		if (lk_ovf) begin
			ref_conn_nxt = 1'b0;
			unlock_irq_nxt = 1'b1;
		end
	end

	// register the supervision state; only reset restores the source
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fail_r <= 1'b0;
			ref_conn_r <= 1'b1;
			owd_irq_o <= 1'b0;
			unlock_irq_o <= 1'b0;
		end else begin
			fail_r <= fail_nxt;
			ref_conn_r <= ref_conn_nxt;
			owd_irq_o <= owd_irq_nxt;
			unlock_irq_o <= unlock_irq_nxt;
		end
	end

	// cpu clock source selection and pll power
	always_comb begin
		cpu_clk_nxt = cpu_clk_o;
		// pll runs when multiplying, when the watchdog needs it, or
		// as the backup; otherwise it is off to save current
		pll_on_nxt = is_mult || !owd_dis || fail_r;
		bypass_nxt = (mode_r == MODE_DIRECT);
		if (fail_r) begin
			cpu_clk_nxt = free_lvl; // backup clock
		end else begin
			unique case (mode_r)
				MODE_DIRECT: begin
					// halves follow the input duty cycle
					cpu_clk_nxt = xs2_r;
				end
				MODE_PRESC: begin
					// one input period per phase, half the frequency
					if (x_rise) begin
						cpu_clk_nxt = !cpu_clk_o;
					end
				end
				default: begin
					// multiplying modes; free-run until measured or
					// once the reference is lost
					if (ref_conn_r && per_r != '0) begin
						cpu_clk_nxt = pll_lvl_r;
					end else begin
						cpu_clk_nxt = free_lvl;
					end
				end
			endcase
		end
		// every change of level is a usable edge
		edge_nxt = (cpu_clk_nxt != cpu_clk_o);
	end

	// register the cpu clock and status outputs
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cpu_clk_o <= 1'b0;
			cpu_clk_edge_o <= 1'b0;
			pll_on_o <= 1'b1;
			osc_amp_bypass_o <= 1'b0;
			backup_active_o <= 1'b0;
			clock_mode_o <= MODE_RST;
			clk_factor_o <= 5'h04;
		end else begin
			cpu_clk_o <= cpu_clk_nxt;
			cpu_clk_edge_o <= edge_nxt;
			pll_on_o <= pll_on_nxt;
			osc_amp_bypass_o <= bypass_nxt;
			backup_active_o <= fail_r || !ref_conn_r;
			clock_mode_o <= mode_r;
			clk_factor_o <= fac;
		end
	end

	// checks
	a_mode_held: assert property (@(posedge clk_i) disable iff (rst_i)
		taken_r |=> $stable(mode_r))
		else $error("mode changed after it was taken");
	a_mode_taken: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(taken_r) |-> mode_r == $past(mp2_r))
		else $error("mode not taken from the pins");
	a_presc_half: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_r == MODE_PRESC && !fail_r && x_rise) |=>
		(cpu_clk_o != $past(cpu_clk_o)))
		else $error("prescaler did not toggle on input rise");
	a_direct_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_r == MODE_DIRECT && !fail_r) |=> cpu_clk_o == $past(xs2_r))
		else $error("direct drive does not follow input");
	a_owd_switch: assert property (@(posedge clk_i) disable iff (rst_i)
		wd_ovf |=> fail_r && owd_irq_o ##1 backup_active_o)
		else $error("watchdog overflow did not switch source");
	a_backup_stays: assert property (@(posedge clk_i) disable iff (rst_i)
		fail_r |=> fail_r [*8])
		else $error("backup clock was released");
	a_pll_off_dis: assert property (@(posedge clk_i) disable iff (rst_i)
		(!is_mult && owd_dis && !fail_r) |=> !pll_on_o)
		else $error("pll on with watchdog disabled");
	a_irq_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		(wd_ovf && owd_irq_clr_i) |=> owd_irq_o)
		else $error("watchdog irq lost against a clear");
	a_unlock_disc: assert property (@(posedge clk_i) disable iff (rst_i)
		lk_ovf |=> !ref_conn_r && unlock_irq_o)
		else $error("unlock did not disconnect reference");
	a_edge_mark: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(cpu_clk_o) |-> cpu_clk_edge_o)
		else $error("cpu clock edge not marked");
	a_wd_mult_off: assert property (@(posedge clk_i) disable iff (rst_i)
		is_mult |-> !wd_ovf && !fail_r)
		else $error("watchdog active in a multiplying mode");
endmodule : cgw_clock_gen

//--- tb/cgw_osc_src.sv
// Purpose: model of the clock source on the oscillator input pin
// Assumes: half periods given in system clock cycles
// Notes:   a stopped source holds its level, as a dead crystal would
`timescale 1ns/1ps
module cgw_osc_src (
	// clock
	input wire logic clk_i,
	// control of the source
	input wire logic run_i,
	input wire logic [7:0] hi_cyc_i,
	input wire logic [7:0] lo_cyc_i,
	// level on the oscillator input pin
	output logic osc_o
);
	// cycles spent in the current phase
	logic [7:0] cnt_r = 8'h00;
	initial osc_o = 1'b0;

	// toggle after each programmed phase; the same wire serves a crystal
	// or a forced clock, the mode decides which is legal
	always @(posedge clk_i) begin
		if (run_i) begin
			// phase over: flip the pin and restart the count
			if (cnt_r + 8'h01 >= (osc_o ? hi_cyc_i : lo_cyc_i)) begin
				osc_o <= ~osc_o;
				cnt_r <= 8'h00;
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end
endmodule : cgw_osc_src

//--- tb/tb_cpu_clock_generation_and_osc_watchdog.sv
// Purpose: self-checking bench of the cpu clock generator
// Assumes: 125 MHz system clock, source model on the oscillator pin
// Notes:   phase lengths are measured in whole system cycles
`timescale 1ns/1ps
module tb_cpu_clock_generation_and_osc_watchdog import cgw_pkg::*;;
	// stimulus and observed signals
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [2:0] mode_pins = 3'h7;
	logic [SYSCFG_W-1:0] cfg = '0;
	logic owd_clr = 1'b0;
	logic unl_clr = 1'b0;
	logic run = 1'b1;
	logic [7:0] hi_cyc = 8'h04;
	logic [7:0] lo_cyc = 8'h04;
	logic osc, cpu_clk_o, cpu_clk_edge_o, pll_on_o, bypass_o;
	logic backup_o, owd_irq_o, unlock_irq_o;
	logic prev_cpu = 1'b0; // cpu clock level seen at the last sample
	logic [2:0] mode_o;
	logic [4:0] factor_o;
	int errors = 0;
	int comparisons = 0;

	cgw_osc_src src_u (.clk_i(clk_i), .run_i(run), .hi_cyc_i(hi_cyc),
		.lo_cyc_i(lo_cyc), .osc_o(osc));

	cgw_clock_gen dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.osc_input_pin_i(osc), .clock_mode_pins_i(mode_pins),
		.system_config_register_i(cfg), .owd_irq_clr_i(owd_clr),
		.unlock_irq_clr_i(unl_clr), .cpu_clk_o(cpu_clk_o),
		.cpu_clk_edge_o(cpu_clk_edge_o), .clock_mode_o(mode_o),
		.clk_factor_o(factor_o), .pll_on_o(pll_on_o),
		.osc_amp_bypass_o(bypass_o), .backup_active_o(backup_o),
		.owd_irq_o(owd_irq_o), .unlock_irq_o(unlock_irq_o));

	// 8 ns system clock
	initial begin
		forever #4 clk_i = ~clk_i;
	end

	// compare one value, count it, report a mismatch
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// sample point one step after the rising edge, outputs settled
	task automatic step();
		@(posedge clk_i);
		#1;
	endtask : step

	// full reset with given straps and config, 16 cycles of reset
	task automatic do_reset(input logic [2:0] code, input logic [15:0] c);
		@(posedge clk_i);
		rst_i <= 1'b1;
		mode_pins <= code;
		cfg <= c;
		run <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		// straps held well past the third edge after release
		repeat (8) @(posedge clk_i);
		#1;
	endtask : do_reset

	// lengths of one high and one low cpu clock phase, bounded wait
	task automatic measure(output int hi, output int lo);
		int n;
		n = 0;
		hi = 0;
		lo = 0;
		while (cpu_clk_o !== 1'b0 && n < 400) begin step(); n++; end
		while (cpu_clk_o !== 1'b1 && n < 400) begin step(); n++; end
		while (cpu_clk_o === 1'b1 && n < 400) begin step(); n++; hi++; end
		while (cpu_clk_o === 1'b0 && n < 400) begin step(); n++; lo++; end
	endtask : measure

	// the edge pulse marks every change of the cpu clock, either way
	always @(posedge clk_i) begin
		#1;
		if (rst_i === 1'b0) check(32'(cpu_clk_edge_o), 32'(cpu_clk_o ^ prev_cpu));
		prev_cpu = cpu_clk_o;
	end

	// values held in reset, then every strap code in turn
	task automatic t_modes();
		logic [4:0] fac [8];
		fac = '{5'h10, 5'h00, 5'h0A, 5'h01, 5'h05, 5'h08, 5'h03, 5'h04};
		step();
		check(32'({mode_o, factor_o, pll_on_o}), 32'h1C9);
		check(32'({backup_o, owd_irq_o, unlock_irq_o, cpu_clk_o}), 32'h0);
		for (int i = 0; i < 8; i++) begin
			// watchdog off, so the pll runs only in multiplying modes
			do_reset(3'(i), 16'h0010);
			check(32'(mode_o), 32'(i));
			check(32'(factor_o), 32'(fac[i]));
			check(32'(pll_on_o), 32'(i != 3 && i != 1));
			check(32'(bypass_o), 32'(i == 3));
		end
	endtask : t_modes

	// direct drive keeps the duty cycle, prescaler stretches phases
	task automatic t_direct_presc();
		int hi, lo;
		hi_cyc <= 8'h03;
		lo_cyc <= 8'h05;
		do_reset(MODE_DIRECT, 16'h0000);
		check(32'(pll_on_o), 32'h1);
		measure(hi, lo);
		check(32'(hi), 32'h3);
		check(32'(hi + lo), 32'h8);
		hi_cyc <= 8'h03;
		lo_cyc <= 8'h07;
		do_reset(MODE_PRESC, 16'h0000);
		measure(hi, lo);
		check(32'(hi), 32'hA);
		check(32'(lo), 32'hA);
	endtask : t_direct_presc

	// source dies: backup clock, sticky flag, only reset recovers
	task automatic t_owd_fail();
		int n, hi, lo;
		hi_cyc <= 8'h04;
		lo_cyc <= 8'h04;
		do_reset(MODE_DIRECT, 16'h0000);
		check(32'(owd_irq_o), 32'h0);
		@(posedge clk_i);
		run <= 1'b0;
		n = 0;
		while (owd_irq_o !== 1'b1 && n < 300) begin step(); n++; end
		// 16 free ticks of 8 cycles, less the running phase, plus sync
		check(32'(n >= 100 && n <= 160), 32'h1);
		repeat (3) step();
		check(32'(backup_o), 32'h1);
		measure(hi, lo);
		check(32'(hi), 32'(FREE_HALF_CYC));
		@(posedge clk_i);
		run <= 1'b1;
		repeat (60) step();
		check(32'({backup_o, owd_irq_o}), 32'h3);
		@(posedge clk_i);
		owd_clr <= 1'b1;
		@(posedge clk_i);
		owd_clr <= 1'b0;
		#1;
		check(32'(owd_irq_o), 32'h0);
		do_reset(MODE_DIRECT, 16'h0000);
		check(32'(backup_o), 32'h0);
	endtask : t_owd_fail

	// watchdog disabled: pll off and a dead source goes unnoticed
	task automatic t_owd_off();
		do_reset(MODE_PRESC, 16'h0010);
		check(32'(pll_on_o), 32'h0);
		@(posedge clk_i);
		run <= 1'b0;
		repeat (300) step();
		check(32'({backup_o, owd_irq_o, pll_on_o}), 32'h0);
	endtask : t_owd_off

	// x4 pll tracks the input, then unlock on a dead reference
	task automatic t_pll();
		int n, edges;
		hi_cyc <= 8'h08;
		lo_cyc <= 8'h08;
		do_reset(MODE_X4, 16'h0010);
		repeat (300) step();
		edges = 0;
		for (int i = 0; i < 160; i++) begin
			step();
			if (cpu_clk_edge_o === 1'b1) edges++;
		end
		// ten input periods give forty cpu periods, small jitter allowed
		check(32'(edges >= 76 && edges <= 84), 32'h1);
		check(32'({backup_o, unlock_irq_o}), 32'h0);
		@(posedge clk_i);
		run <= 1'b0;
		n = 0;
		while (unlock_irq_o !== 1'b1 && n < 500) begin step(); n++; end
		check(32'(n < 500), 32'h1);
		repeat (3) step();
		check(32'({backup_o, owd_irq_o}), 32'h2);
		@(posedge clk_i);
		unl_clr <= 1'b1;
		@(posedge clk_i);
		unl_clr <= 1'b0;
		#1;
		check(32'(unlock_irq_o), 32'h0);
	endtask : t_pll

	// single place where the run ends
	task automatic give_verdict();
		if (errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	// main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		t_modes();
		t_direct_presc();
		t_owd_fail();
		t_owd_off();
		t_pll();
		give_verdict();
	end

	// hang guard, far beyond the few thousand cycles the tests need
	initial begin
		#(20000 * 8);
		errors++;
		give_verdict();
	end
endmodule : tb_cpu_clock_generation_and_osc_watchdog
